// >>> core/pmcs_pkg.sv
// pmcs_pkg: offsets, field layout, reset values and carrier types for the power control register
package pmcs_pkg;

  // register byte offsets
  localparam logic [11:0] PMCS_PM_CTRL_OFS  = 12'h0C4;
  localparam logic [11:0] PMCS_IRQ_STAT_OFS = 12'h100;
  localparam logic [11:0] PMCS_IRQ_MASK_OFS = 12'h104;

  // field positions within the power control and status word
  localparam int PMCS_PS_LSB   = 0;
  localparam int PMCS_PS_MSB   = 1;
  localparam int PMCS_CTX_BIT  = 3;
  localparam int PMCS_WEN_BIT  = 8;
  localparam int PMCS_WST_BIT  = 15;

  // power state codes
  localparam logic [1:0] PMCS_PS_D0    = 2'h0;
  localparam logic [1:0] PMCS_PS_D1    = 2'h1;
  localparam logic [1:0] PMCS_PS_D2    = 2'h2;
  localparam logic [1:0] PMCS_PS_D3HOT = 2'h3;

  // reset values
  localparam logic [1:0] PMCS_PS_RST   = 2'h0;
  localparam logic       PMCS_CTX_RST  = 1'h1;
  localparam logic       PMCS_WEN_RST  = 1'h0;
  localparam logic       PMCS_WST_RST  = 1'h0;
  localparam logic [2:0] PMCS_IRQ_RST  = 3'h0;

  // interrupt status and mask layout
  localparam int PMCS_IRQ_W     = 3;
  localparam int PMCS_IRQ_WAKE  = 0;
  localparam int PMCS_IRQ_PSCHG = 1;
  localparam int PMCS_IRQ_BADPS = 2;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pmcs_req_t;

endpackage : pmcs_pkg

// >>> core/pmcs_ctrl.sv
// pmcs_ctrl: per-port power management control and status register with wake event tracking
`timescale 1ns/1ns

module pmcs_ctrl
  import pmcs_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0
) (
  // clock and resets
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hot_reset,
  // register port
  input  wire pmcs_req_t   reg_req,
  output logic      [31:0] reg_rdata,
  // wake events and messages
  input  wire logic        port_wake_event,
  input  wire logic        fwd_wake_msg,
  output logic             wake_msg_req,
  output logic             wake_fwd_out,
  // power and context
  input  wire logic        ctx_unlock,
  output logic       [1:0] power_state,
  output logic             context_preserved_flag,
  output logic             ctx_reset_req,
  // interrupt
  output logic             irq
);

  // ---------------------------------------------------------------- decode
  wire logic       pm_sel   = (reg_req.addr == PMCS_PM_CTRL_OFS);
  wire logic       st_sel   = (reg_req.addr == PMCS_IRQ_STAT_OFS);
  wire logic       mk_sel   = (reg_req.addr == PMCS_IRQ_MASK_OFS);
  wire logic       wr_pm    = reg_req.wr & pm_sel;
  wire logic       wr_st    = reg_req.wr & st_sel;
  wire logic       wr_mk    = reg_req.wr & mk_sel;
  wire logic [1:0] ps_wdata = reg_req.wdata[PMCS_PS_MSB:PMCS_PS_LSB];

  // ---------------------------------------------------------------- state
  logic [1:0]            ps_r;
  logic [1:0]            ps_nxt;
  logic                  ctx_r;
  logic                  ctx_nxt;
  logic                  wen_r;
  logic                  wen_nxt;
  logic                  wst_r;
  logic                  wst_nxt;
  logic [PMCS_IRQ_W-1:0] stat_r;
  logic [PMCS_IRQ_W-1:0] stat_nxt;
  logic [PMCS_IRQ_W-1:0] mask_r;
  logic [PMCS_IRQ_W-1:0] mask_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic [31:0]           pm_word;
  logic                  wmsg_r;
  logic                  fwd_r;
  logic                  ctxrst_r;
  logic                  irq_r;

  // only the two supported codes are accepted; D1/D2 writes leave the state as it was
  wire logic ps_legal = (ps_wdata == PMCS_PS_D0) | (ps_wdata == PMCS_PS_D3HOT);
  wire logic ps_write = wr_pm & ps_legal;
  wire logic ps_bad   = wr_pm & ~ps_legal;
  wire logic ps_chg   = ps_write & (ps_wdata != ps_r);

  // leaving D3hot for D0 asks the core to reset its context unless it is kept
  wire logic d3_exit  = ps_write & (ps_r == PMCS_PS_D3HOT) & (ps_wdata == PMCS_PS_D0);

  // the upstream port never originates a wake event
  wire logic own_wake = port_wake_event & ~IS_UPSTREAM;

  // hot reset returns power state and context to their reset values; interrupt status and mask keep theirs
  assign ps_nxt  = hot_reset ? PMCS_PS_RST :
                   ps_write  ? ps_wdata    : ps_r;
  // write-locked: only while the init path holds the unlock
  assign ctx_nxt = hot_reset             ? PMCS_CTX_RST                 :
                   (wr_pm & ctx_unlock)  ? reg_req.wdata[PMCS_CTX_BIT] : ctx_r;
  // sticky: hot reset does not touch it
  assign wen_nxt = wr_pm ? reg_req.wdata[PMCS_WEN_BIT] : wen_r;
  // set wins over a same-cycle write-one clear; forwarded messages play no part
  assign wst_nxt = own_wake |
                   (wst_r & ~(wr_pm & reg_req.wdata[PMCS_WST_BIT]));

  wire logic [PMCS_IRQ_W-1:0] irq_ev;
  assign irq_ev[PMCS_IRQ_WAKE]  = own_wake;
  assign irq_ev[PMCS_IRQ_PSCHG] = ps_chg;
  assign irq_ev[PMCS_IRQ_BADPS] = ps_bad;

  wire logic [PMCS_IRQ_W-1:0] irq_clr = wr_st ? reg_req.wdata[PMCS_IRQ_W-1:0]
                                              : {PMCS_IRQ_W{1'b0}};
  assign stat_nxt = irq_ev | (stat_r & ~irq_clr);
  assign mask_nxt = wr_mk ? reg_req.wdata[PMCS_IRQ_W-1:0] : mask_r;

  // read word: unimplemented and reserved positions stay zero
  always_comb begin
    pm_word                              = 32'h0000_0000;
    pm_word[PMCS_PS_MSB:PMCS_PS_LSB]     = ps_r;
    pm_word[PMCS_CTX_BIT]                = ctx_r;
    pm_word[PMCS_WEN_BIT]                = wen_r;
    pm_word[PMCS_WST_BIT]                = wst_r;
  end

  wire logic [31:0] stat_word = {{(32-PMCS_IRQ_W){1'b0}}, stat_r};
  wire logic [31:0] mask_word = {{(32-PMCS_IRQ_W){1'b0}}, mask_r};

  // unmapped addresses read zero; data stands only in the cycle after the strobe
  assign rdata_nxt = ~reg_req.rd ? 32'h0000_0000 :
                     pm_sel      ? pm_word       :
                     st_sel      ? stat_word     :
                     mk_sel      ? mask_word     : 32'h0000_0000;

  // ---------------------------------------------------------------- flops
  // sticky fields follow only the fundamental reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wen_r <= PMCS_WEN_RST;
      wst_r <= PMCS_WST_RST;
    end else begin
      wen_r <= wen_nxt;
      wst_r <= wst_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_r   <= PMCS_PS_RST;
      ctx_r  <= PMCS_CTX_RST;
      stat_r <= PMCS_IRQ_RST;
      mask_r <= PMCS_IRQ_RST;
    end else begin
      ps_r   <= ps_nxt;
      ctx_r  <= ctx_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r  <= 32'h0000_0000;
      wmsg_r   <= 1'b0;
      fwd_r    <= 1'b0;
      ctxrst_r <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      wmsg_r   <= own_wake & wen_r;
      fwd_r    <= fwd_wake_msg;
      ctxrst_r <= d3_exit & ~ctx_r;
      irq_r    <= |(stat_r & mask_r);
    end
  end

  assign reg_rdata              = rdata_r;
  assign wake_msg_req           = wmsg_r;
  assign wake_fwd_out           = fwd_r;
  assign power_state            = ps_r;
  assign context_preserved_flag = ctx_r;
  assign ctx_reset_req          = ctxrst_r;
  assign irq                    = irq_r;

  // ---------------------------------------------------------------- checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_pm_write(logic [1:0] code);
    wr_pm && !hot_reset && (ps_wdata == code);
  endsequence

  sequence s_pm_read;
    reg_req.rd && pm_sel;
  endsequence

  state_legal_a: assert property (
    (ps_r != PMCS_PS_D1) && (ps_r != PMCS_PS_D2))
    else $error("power state holds an unsupported code");

  state_write_a: assert property (
    s_pm_write(PMCS_PS_D3HOT) |=> (power_state == PMCS_PS_D3HOT))
    else $error("D3hot write did not take effect");

  bad_write_a: assert property (
    s_pm_write(PMCS_PS_D1) or s_pm_write(PMCS_PS_D2) |=> $stable(power_state))
    else $error("unsupported power state write changed the state");

  read_resv_a: assert property (
    s_pm_read |=> (reg_rdata[31:16] == 16'h0000) && (reg_rdata[14:9] == 6'h00)
                  && (reg_rdata[7:4] == 4'h0) && !reg_rdata[2])
    else $error("reserved or unimplemented field read nonzero");

  ctx_read_a: assert property (
    s_pm_read |=> (reg_rdata[PMCS_CTX_BIT] == $past(ctx_r)))
    else $error("context flag read differs from held value");

  wake_gate_a: assert property (
    wake_msg_req |-> $past(wen_r) && $past(port_wake_event))
    else $error("wake message issued without enable");

  hot_sticky_a: assert property (
    hot_reset && !wr_pm |=> (wen_r == $past(wen_r)) && (wst_r >= $past(wst_r)))
    else $error("sticky field altered by hot reset");

  wake_set_a: assert property (
    own_wake |=> wst_r ##0 (pm_word[PMCS_WST_BIT] == 1'b1))
    else $error("own wake event did not set status");

  w1c_clear_a: assert property (
    wr_pm && reg_req.wdata[PMCS_WST_BIT] && !own_wake |=> !wst_r)
    else $error("write-one did not clear wake status");

  fwd_quiet_a: assert property (
    fwd_wake_msg && !port_wake_event && !wr_pm |=> $stable(wst_r))
    else $error("forwarded message changed wake status");

  up_zero_a: assert property (
    IS_UPSTREAM |-> !wst_r && !wake_msg_req)
    else $error("upstream port shows a wake event");

  sequence s_own_wake;
    port_wake_event && !IS_UPSTREAM;
  endsequence

  sequence s_d3_to_d0;
    wr_pm && !hot_reset && (power_state == PMCS_PS_D3HOT) && (ps_wdata == PMCS_PS_D0);
  endsequence

  state_d0_a: assert property (
    s_pm_write(PMCS_PS_D0) |=> (power_state == PMCS_PS_D0))
    else $error("D0 write did not take effect");

  state_hold_a: assert property (
    !wr_pm && !hot_reset |=> $stable(power_state))
    else $error("power state moved without a write");

  hot_state_a: assert property (
    hot_reset |=> (power_state == PMCS_PS_RST))
    else $error("hot reset did not return the power state to D0");

  hot_ctx_a: assert property (
    hot_reset |=> (context_preserved_flag == PMCS_CTX_RST))
    else $error("hot reset did not restore the context flag");

  ctx_lock_a: assert property (
    !ctx_unlock && !hot_reset |=> $stable(context_preserved_flag))
    else $error("context flag changed while locked");

  ctx_write_a: assert property (
    wr_pm && ctx_unlock && !hot_reset |=> (context_preserved_flag == $past(reg_req.wdata[3])))
    else $error("unlocked context flag write did not land");

  ctx_reset_a: assert property (
    s_d3_to_d0 ##0 !context_preserved_flag |=> ctx_reset_req)
    else $error("context reset not requested on wake without preservation");

  ctx_keep_a: assert property (
    ctx_reset_req |-> ($past(power_state) == PMCS_PS_D3HOT) && !$past(context_preserved_flag))
    else $error("context reset requested without cause");

  ctx_pulse_a: assert property (
    ctx_reset_req |=> !ctx_reset_req)
    else $error("context reset request longer than one cycle");

  wen_write_a: assert property (
    wr_pm |=> (wen_r == $past(reg_req.wdata[PMCS_WEN_BIT])))
    else $error("wake enable write did not land");

  wen_hold_a: assert property (
    !wr_pm |=> $stable(wen_r))
    else $error("wake enable changed without a write");

  wake_msg_a: assert property (
    s_own_wake ##0 wen_r |=> wake_msg_req)
    else $error("enabled wake event issued no message");

  wake_quiet_a: assert property (
    !wen_r |=> !wake_msg_req)
    else $error("wake message while enable clear");

  wst_hold_a: assert property (
    !own_wake && !(wr_pm && reg_req.wdata[PMCS_WST_BIT]) |=> $stable(wst_r))
    else $error("wake status changed without event or clear");

  wst_read_a: assert property (
    s_pm_read |=> (reg_rdata[PMCS_WST_BIT] == $past(wst_r)))
    else $error("wake status read differs from held value");

  set_wins_a: assert property (
    s_own_wake ##0 (wr_pm && reg_req.wdata[PMCS_WST_BIT]) |=> wst_r)
    else $error("same-cycle clear beat the wake event");

  stat_clr_a: assert property (
    wr_st && reg_req.wdata[PMCS_IRQ_WAKE] && !own_wake |=> !stat_r[PMCS_IRQ_WAKE])
    else $error("write-one did not clear the wake interrupt flag");

  fwd_copy_a: assert property (
    fwd_wake_msg |=> wake_fwd_out)
    else $error("forwarded message not passed on");

  fwd_drop_a: assert property (
    !fwd_wake_msg |=> !wake_fwd_out)
    else $error("forward output without a forwarded message");

  up_msg_a: assert property (
    IS_UPSTREAM |-> !stat_r[PMCS_IRQ_WAKE])
    else $error("upstream port flagged a wake interrupt");

  up_read_a: assert property (
    IS_UPSTREAM && reg_req.rd && pm_sel |=> !reg_rdata[PMCS_WST_BIT])
    else $error("upstream port read a set wake status");

  read_ps_a: assert property (
    s_pm_read |=> (reg_rdata[PMCS_PS_MSB:PMCS_PS_LSB] == $past(power_state)))
    else $error("power state read differs from held value");

  read_wen_a: assert property (
    s_pm_read |=> (reg_rdata[PMCS_WEN_BIT] == $past(wen_r)))
    else $error("wake enable read differs from held value");

  data_zero_a: assert property (
    s_pm_read |=> (reg_rdata[31:24] == 8'h00) && (reg_rdata[14:9] == 6'h00))
    else $error("power data fields read nonzero");

  bus_zero_a: assert property (
    s_pm_read |=> (reg_rdata[23:22] == 2'h0))
    else $error("bus state support bits read nonzero");

  bad_flag_a: assert property (
    s_pm_write(PMCS_PS_D1) or s_pm_write(PMCS_PS_D2) |=> stat_r[PMCS_IRQ_BADPS])
    else $error("unsupported state write not flagged");

  chg_flag_a: assert property (
    wr_pm && ps_legal && (ps_wdata != power_state) |=> stat_r[PMCS_IRQ_PSCHG])
    else $error("power state change not flagged");

  wake_flag_a: assert property (
    s_own_wake |=> stat_r[PMCS_IRQ_WAKE])
    else $error("own wake event not flagged");

  wake_irq_a: assert property (
    stat_r[PMCS_IRQ_WAKE] && mask_r[PMCS_IRQ_WAKE] |=> irq)
    else $error("unmasked wake flag raised no interrupt");

  irq_low_a: assert property (
    ((stat_r & mask_r) == {PMCS_IRQ_W{1'b0}}) |=> !irq)
    else $error("interrupt without an unmasked flag");

endmodule : pmcs_ctrl

// >>> verif/pmcs_ctrl_test.sv
// pmcs_ctrl_test: self-checking bench for the power control and status register
`timescale 1ns/1ns
module pmcs_ctrl_test;
  import pmcs_pkg::*;
  logic        clk, reset_n, hot_reset, port_wake_event, fwd_wake_msg, ctx_unlock;
  pmcs_req_t   reg_req;
  logic [31:0] reg_rdata, up_rdata, rd_val, up_val;
  logic        wake_msg_req, wake_fwd_out, context_preserved_flag, ctx_reset_req, irq;
  logic [1:0]  power_state;
  int          err_count, n_compared;
  // rows: word written to the register, word read back, power state expected
  logic [31:0] tab_wd [5] = '{32'h00000003, 32'h00000001, 32'h00000002, 32'hFFFF7EF0, 32'h00000100};
  logic [31:0] tab_rd [5] = '{32'h0000000B, 32'h0000000B, 32'h0000000B, 32'h00000008, 32'h00000108};
  logic [1:0]  tab_ps [5] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0};

  pmcs_ctrl dut (.clk(clk), .reset_n(reset_n), .hot_reset(hot_reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .port_wake_event(port_wake_event), .fwd_wake_msg(fwd_wake_msg),
    .wake_msg_req(wake_msg_req), .wake_fwd_out(wake_fwd_out), .ctx_unlock(ctx_unlock),
    .power_state(power_state), .context_preserved_flag(context_preserved_flag),
    .ctx_reset_req(ctx_reset_req), .irq(irq));
  // upstream instance shares every input; only its read data is watched
  pmcs_ctrl #(.IS_UPSTREAM(1'b1)) dut_up (.clk(clk), .reset_n(reset_n), .hot_reset(hot_reset),
    .reg_req(reg_req), .reg_rdata(up_rdata), .port_wake_event(port_wake_event),
    .fwd_wake_msg(fwd_wake_msg), .wake_msg_req(), .wake_fwd_out(), .ctx_unlock(ctx_unlock),
    .power_state(), .context_preserved_flag(), .ctx_reset_req(), .irq());

  always #5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) reg_req <= '0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the taking edge
  task automatic rd(input logic [11:0] a);
    @(posedge clk) reg_req <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge clk) reg_req <= '0;
    #1;
    rd_val = reg_rdata;
    up_val = up_rdata;
  endtask : rd

  task automatic wait2;
    repeat (2) @(posedge clk);
    #1;
  endtask : wait2

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  initial begin
    #20000;
    err_count++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    {reset_n, hot_reset, port_wake_event, fwd_wake_msg, ctx_unlock} <= 5'h00;
    reg_req <= '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(PMCS_PM_CTRL_OFS);
    check("pm_rst", rd_val, 32'h00000008);
    rd(PMCS_IRQ_STAT_OFS);
    check("stat_rst", rd_val, 32'h00000000);
    rd(12'h0C8);
    check("unmapped", rd_val, 32'h00000000);
    // last row sets the wake enable early, as firmware would during load
    for (int i = 0; i < 5; i++) begin
      wr(PMCS_PM_CTRL_OFS, tab_wd[i]);
      check("power_state", {30'h0, power_state}, {30'h0, tab_ps[i]});
      rd(PMCS_PM_CTRL_OFS);
      check("pm_row", rd_val, tab_rd[i]);
    end
    @(posedge clk) fwd_wake_msg <= 1'b1;
    @(posedge clk) fwd_wake_msg <= 1'b0;
    #1 check("fwd_out", {31'h0, wake_fwd_out}, 32'h1);
    rd(PMCS_PM_CTRL_OFS);
    check("fwd_no_status", rd_val, 32'h00000108);
    @(posedge clk) port_wake_event <= 1'b1;
    @(posedge clk) port_wake_event <= 1'b0;
    #1 check("wake_msg", {31'h0, wake_msg_req}, 32'h1);
    rd(PMCS_PM_CTRL_OFS);
    check("wake_status", rd_val, 32'h00008108);
    check("up_status", up_val, 32'h00000108);
    wr(PMCS_PM_CTRL_OFS, 32'h00000103);
    @(posedge clk) hot_reset <= 1'b1;
    @(posedge clk) hot_reset <= 1'b0;
    rd(PMCS_PM_CTRL_OFS);
    check("hot_reset", rd_val, 32'h00008108);
    wr(PMCS_PM_CTRL_OFS, 32'h00008100);
    rd(PMCS_PM_CTRL_OFS);
    check("w1c", rd_val, 32'h00000108);
    // every event kind has fired by now: own wake, state changes, refused codes
    rd(PMCS_IRQ_STAT_OFS);
    check("stat_all", rd_val, 32'h00000007);
    // status bit 0 still holds the earlier wake event
    wr(PMCS_IRQ_MASK_OFS, 32'h00000001);
    wait2();
    check("irq_on", {31'h0, irq}, 32'h1);
    rd(PMCS_IRQ_MASK_OFS);
    check("mask_rd", rd_val, 32'h00000001);
    wr(PMCS_IRQ_STAT_OFS, 32'h00000007);
    wait2();
    check("irq_clr", {31'h0, irq}, 32'h0);
    @(posedge clk) port_wake_event <= 1'b1;
    @(posedge clk) port_wake_event <= 1'b0;
    wait2();
    check("irq_wake", {31'h0, irq}, 32'h1);
    wr(PMCS_IRQ_MASK_OFS, 32'h00000000);
    wait2();
    check("irq_masked", {31'h0, irq}, 32'h0);
    // wake event and write-one clear in one cycle: the set must win
    @(posedge clk) begin
      reg_req         <= '{PMCS_PM_CTRL_OFS, 32'h00008100, 1'b1, 1'b0};
      port_wake_event <= 1'b1;
    end
    @(posedge clk) begin
      reg_req         <= '0;
      port_wake_event <= 1'b0;
    end
    rd(PMCS_PM_CTRL_OFS);
    check("set_wins", rd_val, 32'h00008108);
    @(posedge clk) ctx_unlock <= 1'b1;
    wr(PMCS_PM_CTRL_OFS, 32'h00000003);
    check("ctx_clear", {31'h0, context_preserved_flag}, 32'h0);
    // the request pulse stands only in the cycle after the taking edge
    @(posedge clk) reg_req <= '{PMCS_PM_CTRL_OFS, 32'h00000000, 1'b1, 1'b0};
    @(posedge clk) reg_req <= '0;
    #1 check("ctx_reset_req", {31'h0, ctx_reset_req}, 32'h1);
    @(posedge clk) #1 check("ctx_req_drop", {31'h0, ctx_reset_req}, 32'h0);
    @(posedge clk) hot_reset <= 1'b1;
    @(posedge clk) hot_reset <= 1'b0;
    #1 check("hot_ctx", {31'h0, context_preserved_flag}, 32'h1);
    @(posedge clk) reset_n <= 1'b0;
    @(posedge clk) reset_n <= 1'b1;
    rd(PMCS_PM_CTRL_OFS);
    check("cold_reset", rd_val, 32'h00000008);
    close_out();
  end
endmodule : pmcs_ctrl_test
